// ===== shift_mac_unit.sv
// Shifter and accumulator store datapath with a classic Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Logical shifts load dest_reg with src_reg shifted left or right by amount_reg.
// - Logical shifts drop bits leaving the word and fill vacated bits with zero.
// - Record forms update cond_field_zero; plain forms leave it alone.
// - Logical shifts change no bit of the fixed-point exception register.
// - Every algebraic right shift updates carry_flag.
// - Immediate algebraic shift counts from shift_imm_field, register form from amount_reg.
// - Record algebraic shifts update cond_field_zero and carry_flag together.
// - Algebraic right shift drops low bits and fills high bits with old sign.
// - Accumulate results are held 33 bits wide before write back.
// - Modulo forms drop the top bit and store the low word.
// - Saturating forms store the low word unchanged when it fits.
// - Signed saturation above the largest positive word stores that word.
// - Signed saturation below the most negative word stores that word.
// - Unsigned saturation above all-ones stores the all-ones word.
// - No shift alters the overflow or summary-overflow flags.
// - Documented bit 0 is the MSB; left shifts move toward it.
module shift_mac_unit
	import shift_mac_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [shift_mac_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [shift_mac_pkg::WORD_W-1:0] wb_dat_i,
	output logic [shift_mac_pkg::WORD_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [shift_mac_pkg::WORD_W-1:0] dest_reg,
	output logic [3:0] cond_field_zero,
	output logic [2:0] fixed_point_exception_register
);
	import shift_mac_pkg::*;

	// Merges a write into a register one byte lane at a time.
	function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_v,
			input logic [WORD_W-1:0] new_v, input logic [3:0] sel);
		logic [WORD_W-1:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// Builds the condition field from a signed result and the summary flag.
	function automatic logic [3:0] cond_of(input logic [WORD_W-1:0] res, input logic so);
		logic [3:0] c;
		c = 4'h0;
		c[COND_LT_BIT] = res[WORD_W-1];
		c[COND_GT_BIT] = !res[WORD_W-1] && (res != WORD_RST);
		c[COND_EQ_BIT] = (res == WORD_RST);
		c[COND_SO_BIT] = so;
		return c;
	endfunction

	logic [WORD_W-1:0] src_r;
	logic [WORD_W-1:0] amount_r;
	logic [WORD_W-1:0] ctrl_r;
	logic [WORD_W-1:0] acc_lo_r;
	logic acc_hi_r;
	logic [WORD_W-1:0] dest_r;
	logic [3:0] cond_r;
	logic [2:0] fpx_r;
	logic ack_r;
	logic [WORD_W-1:0] rdat_r;

	// Bus decode. The slave answers one cycle after the request and never twice in a row.
	wire logic bus_req;
	wire logic wr_take;
	wire logic rd_take;
	wire logic hit_src;
	wire logic hit_amount;
	wire logic hit_ctrl;
	wire logic hit_acc_lo;
	wire logic hit_acc_hi;
	wire logic hit_fpx;

	assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_take = bus_req && wb_we_i;
	assign rd_take = bus_req && !wb_we_i;
	assign hit_src = (wb_adr_i == SRC_OFS);
	assign hit_amount = (wb_adr_i == AMOUNT_OFS);
	assign hit_ctrl = (wb_adr_i == CTRL_OFS);
	assign hit_acc_lo = (wb_adr_i == ACC_LO_OFS);
	assign hit_acc_hi = (wb_adr_i == ACC_HI_OFS);
	assign hit_fpx = (wb_adr_i == FPX_OFS);

	// A write to the command register both stores it and launches the operation.
	wire logic [WORD_W-1:0] ctrl_nxt;
	wire logic go;
	wire op_t op;
	wire logic rec;
	wire logic [IMM_W-1:0] imm_cnt;

	assign ctrl_nxt = lane_merge(ctrl_r, wb_dat_i, wb_sel_i);
	assign go = wr_take && hit_ctrl;
	assign op = op_t'(ctrl_nxt[CTRL_OP_LSB +: CTRL_OP_W]);
	assign rec = ctrl_nxt[CTRL_REC_BIT];
	assign imm_cnt = ctrl_nxt[CTRL_IMM_LSB +: IMM_W];

	// Word bit [31] is documented bit 0, so a left shift here moves toward bit 0.
	wire logic [AMT_W-1:0] reg_cnt;
	wire logic [AMT_W-1:0] alg_cnt;
	wire logic [WORD_W-1:0] shl_res;
	wire logic [WORD_W-1:0] shr_res;
	wire logic [WORD_W-1:0] sra_res;
	wire logic [WORD_W-1:0] lost_mask;
	wire logic alg_carry;

	assign reg_cnt = amount_r[AMT_W-1:0];
	assign alg_cnt = (op == OP_SHR_ALG_IMM) ? {1'b0, imm_cnt} : reg_cnt;
	assign shl_res = src_r << reg_cnt;
	assign shr_res = src_r >> reg_cnt;
	assign sra_res = WORD_W'($signed(src_r) >>> alg_cnt);
	assign lost_mask = ~(SAT_U_MAX << alg_cnt);
	assign alg_carry = src_r[WORD_W-1] && ((src_r & lost_mask) != WORD_RST);

	// The accumulate intermediate stays 33 bits until the store stage folds it.
	wire logic [WORD_W:0] acc_wide;
	wire store_mode_t st_mode;
	wire logic [WORD_W-1:0] mac_res;

	assign acc_wide = {acc_hi_r, acc_lo_r};
	assign st_mode = (op == OP_MAC_SAT_S) ? STORE_SAT_S :
			(op == OP_MAC_SAT_U) ? STORE_SAT_U : STORE_MOD;

	mac_store_sat u_store (
		.wide_res(acc_wide),
		.mode(st_mode),
		.word_res(mac_res)
	);

	// Result and flag selection for the launched operation.
	logic [WORD_W-1:0] res_nxt;
	logic res_we;
	logic ca_we;

	always_comb begin
		res_nxt = dest_r;
		res_we = 1'b0;
		ca_we = 1'b0;
		unique case (op)
			OP_SHL_LOGIC: begin
				res_nxt = shl_res;
				res_we = 1'b1;
			end
			OP_SHR_LOGIC: begin
				res_nxt = shr_res;
				res_we = 1'b1;
			end
			OP_SHR_ALG_IMM, OP_SHR_ALG_REG: begin
				res_nxt = sra_res;
				res_we = 1'b1;
				ca_we = 1'b1;
			end
			OP_MAC_MOD, OP_MAC_SAT_S, OP_MAC_SAT_U: begin
				res_nxt = mac_res;
				res_we = 1'b1;
			end
			OP_NONE: begin
				res_we = 1'b0;
			end
		endcase
	end

	wire logic [WORD_W-1:0] dest_nxt;
	wire logic [3:0] cond_nxt;
	wire logic [2:0] fpx_nxt;
	wire logic [WORD_W-1:0] fpx_merge;
	wire logic [2:0] fpx_wr;
	wire logic [2:0] fpx_op;

	assign dest_nxt = (go && res_we) ? res_nxt : dest_r;
	// Only the carry bit is ever touched by an operation; overflow and summary keep their value.
	assign fpx_op = {fpx_r[FPX_SO_BIT], fpx_r[FPX_OV_BIT], alg_carry};
	assign fpx_merge = lane_merge({29'h0, fpx_r}, wb_dat_i, wb_sel_i);
	assign fpx_wr = fpx_merge[2:0];
	assign fpx_nxt = (go && ca_we) ? fpx_op :
			(wr_take && hit_fpx) ? fpx_wr : fpx_r;
	assign cond_nxt = (go && res_we && rec) ? cond_of(res_nxt, fpx_r[FPX_SO_BIT]) : cond_r;

	// Read data mux; unmapped offsets answer with zero.
	logic [WORD_W-1:0] rdat_nxt;

	always_comb begin
		rdat_nxt = WORD_RST;
		unique case (wb_adr_i)
			SRC_OFS: rdat_nxt = src_r;
			AMOUNT_OFS: rdat_nxt = amount_r;
			CTRL_OFS: rdat_nxt = ctrl_r;
			DEST_OFS: rdat_nxt = dest_r;
			COND_OFS: rdat_nxt = {28'h0, cond_r};
			FPX_OFS: rdat_nxt = {29'h0, fpx_r};
			ACC_LO_OFS: rdat_nxt = acc_lo_r;
			ACC_HI_OFS: rdat_nxt = {31'h0, acc_hi_r};
			default: rdat_nxt = WORD_RST;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			rdat_r <= WORD_RST;
		end else begin
			ack_r <= bus_req;
			rdat_r <= rd_take ? rdat_nxt : WORD_RST;
		end
	end

	// Software-written operand registers.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_r <= WORD_RST;
			amount_r <= WORD_RST;
			ctrl_r <= WORD_RST;
			acc_lo_r <= WORD_RST;
			acc_hi_r <= 1'b0;
		end else if (wr_take) begin
			if (hit_src) src_r <= lane_merge(src_r, wb_dat_i, wb_sel_i);
			if (hit_amount) amount_r <= lane_merge(amount_r, wb_dat_i, wb_sel_i);
			if (hit_ctrl) ctrl_r <= ctrl_nxt;
			if (hit_acc_lo) acc_lo_r <= lane_merge(acc_lo_r, wb_dat_i, wb_sel_i);
			if (hit_acc_hi && wb_sel_i[0]) acc_hi_r <= wb_dat_i[0];
		end
	end

	// Architectural results.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dest_r <= WORD_RST;
			cond_r <= COND_RST;
			fpx_r <= FPX_RST;
		end else begin
			dest_r <= dest_nxt;
			cond_r <= cond_nxt;
			fpx_r <= fpx_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign dest_reg = dest_r;
	assign cond_field_zero = cond_r;
	assign fixed_point_exception_register = fpx_r;
endmodule // shift_mac_unit
`default_nettype wire

// ===== shift_mac_pkg.sv
// Constants and types shared by the shifter and accumulator store datapath.
package shift_mac_pkg;
	localparam int WORD_W = 32;
	localparam int ADR_W = 8;
	localparam int AMT_W = 6;
	localparam int IMM_W = 5;

	// Register byte offsets on the bus.
	localparam logic [ADR_W-1:0] SRC_OFS = 8'h00;
	localparam logic [ADR_W-1:0] AMOUNT_OFS = 8'h04;
	localparam logic [ADR_W-1:0] CTRL_OFS = 8'h08;
	localparam logic [ADR_W-1:0] DEST_OFS = 8'h0C;
	localparam logic [ADR_W-1:0] COND_OFS = 8'h10;
	localparam logic [ADR_W-1:0] FPX_OFS = 8'h14;
	localparam logic [ADR_W-1:0] ACC_LO_OFS = 8'h18;
	localparam logic [ADR_W-1:0] ACC_HI_OFS = 8'h1C;

	// Command register fields.
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 3;
	localparam int CTRL_REC_BIT = 3;
	localparam int CTRL_IMM_LSB = 4;

	// Exception register bit positions and condition field positions.
	localparam int FPX_CA_BIT = 0;
	localparam int FPX_OV_BIT = 1;
	localparam int FPX_SO_BIT = 2;
	localparam int COND_LT_BIT = 3;
	localparam int COND_GT_BIT = 2;
	localparam int COND_EQ_BIT = 1;
	localparam int COND_SO_BIT = 0;

	// Reset values.
	localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
	localparam logic [3:0] COND_RST = 4'h0;
	localparam logic [2:0] FPX_RST = 3'h0;

	// Saturation limits.
	localparam logic [WORD_W-1:0] SAT_POS_MAX = 32'h7FFF_FFFF;
	localparam logic [WORD_W-1:0] SAT_NEG_MIN = 32'h8000_0000;
	localparam logic [WORD_W-1:0] SAT_U_MAX = 32'hFFFF_FFFF;

	typedef enum logic [CTRL_OP_W-1:0] {
		OP_SHL_LOGIC = 3'h0,
		OP_SHR_LOGIC = 3'h1,
		OP_SHR_ALG_IMM = 3'h2,
		OP_SHR_ALG_REG = 3'h3,
		OP_MAC_MOD = 3'h4,
		OP_MAC_SAT_S = 3'h5,
		OP_MAC_SAT_U = 3'h6,
		OP_NONE = 3'h7
	} op_t;

	typedef enum logic [1:0] {
		STORE_MOD,
		STORE_SAT_S,
		STORE_SAT_U
	} store_mode_t;
endpackage : shift_mac_pkg

// ===== mac_store_sat.sv
// Store stage that folds a 33-bit accumulate result into a 32-bit word.
`timescale 1ns/100ps
`default_nettype none
module mac_store_sat
	import shift_mac_pkg::*;
(
	input wire logic [WORD_W:0] wide_res,
	input wire shift_mac_pkg::store_mode_t mode,
	output logic [WORD_W-1:0] word_res
);
	wire logic s_over;
	wire logic s_under;
	wire logic u_over;

	// A signed 33-bit value fits when its top two bits agree.
	assign s_over = !wide_res[WORD_W] && wide_res[WORD_W-1];
	assign s_under = wide_res[WORD_W] && !wide_res[WORD_W-1];
	assign u_over = wide_res[WORD_W];

	always_comb begin
		word_res = wide_res[WORD_W-1:0];
		unique case (mode)
			STORE_MOD: word_res = wide_res[WORD_W-1:0];
			STORE_SAT_S: begin
				if (s_over) begin
					word_res = SAT_POS_MAX;
				end else if (s_under) begin
					word_res = SAT_NEG_MIN;
				end
			end
			STORE_SAT_U: begin
				if (u_over) begin
					word_res = SAT_U_MAX;
				end
			end
			default: word_res = wide_res[WORD_W-1:0];
		endcase
	end
endmodule // mac_store_sat
`default_nettype wire

// ===== shift_mac_unit_properties.sv
// Concurrent checks on the ports of the shifter and accumulator store datapath.
`timescale 1ns/100ps
`default_nettype none
module shift_mac_unit_checker
	import shift_mac_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [shift_mac_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [shift_mac_pkg::WORD_W-1:0] wb_dat_i,
	input wire logic [shift_mac_pkg::WORD_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [shift_mac_pkg::WORD_W-1:0] dest_reg,
	input wire logic [3:0] cond_field_zero,
	input wire logic [2:0] fixed_point_exception_register
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [2:0] op = wb_dat_i[2:0];
	// Only the low lane carries the op and record bits, so writes without it are not judged.
	wire go = req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS && op != 3'h7;
	wire shf = go && op < 3'h4;
	wire [2:0] fpx = fixed_point_exception_register;
	wire [31:0] d = dest_reg;
	AST_ACK_RISE: assert property (req |=> wb_ack_o) else $error("ack missing after a request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data driven outside ack");
	AST_LOGIC_FPX: assert property (go && op < 3'h2 |=> $stable(fpx)) else $error("logical shift changed flags");
	AST_SHIFT_OVSO: assert property (shf |=> $stable(fpx[2:1])) else $error("shift changed ov or so");
	AST_COND_HOLD: assert property (shf && !wb_dat_i[3] |=> $stable(cond_field_zero)) else $error("cond moved");
	AST_COND_VALUE: assert property (go && wb_dat_i[3] |=> cond_field_zero == {d[31], !d[31] && d != '0,
		d == '0, $past(fpx[2])}) else $error("cond does not match result");
	AST_CARRY_SIGN: assert property (go && op[2:1] == 2'b01 |=> !fpx[0] || d[31]) else $error("carry on positive");
	cover property (go && op == 3'h3);
	cover property (go && wb_dat_i[3]);
	cover property ($rose(fpx[0]));
endmodule // shift_mac_unit_checker
bind shift_mac_unit shift_mac_unit_checker chk_i (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dest_reg(dest_reg), .cond_field_zero(cond_field_zero),
	.fixed_point_exception_register(fixed_point_exception_register));
`default_nettype wire

// ===== test_shift_mac_unit.sv
// Self-checking testbench for the shifter and accumulator store datapath.
`timescale 1ns/100ps
`default_nettype none
module test_shift_mac_unit;
	import shift_mac_pkg::*;
	typedef struct {logic [2:0] op; logic rec; logic [31:0] a; logic [7:0] b; logic [32:0] acc;
		logic [31:0] res; logic ca;} row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, dest, rd;
	logic ack;
	logic [3:0] cond, ec;
	logic [2:0] fpx;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	row_t r;
	// Carry from an arithmetic row must survive the logical rows that follow it.
	row_t rows [15] = '{
		'{3'h2, 1'b1, 32'h8000_0001, 8'h01, 33'h0, 32'hC000_0000, 1'b1},
		'{3'h2, 1'b0, 32'h8000_0000, 8'h04, 33'h0, 32'hF800_0000, 1'b0},
		'{3'h3, 1'b1, 32'h8000_0000, 8'h28, 33'h0, 32'hFFFF_FFFF, 1'b1},
		'{3'h0, 1'b1, 32'h8000_0001, 8'h01, 33'h0, 32'h0000_0002, 1'b1},
		'{3'h0, 1'b0, 32'h8000_0001, 8'h20, 33'h0, 32'h0000_0000, 1'b1},
		'{3'h1, 1'b1, 32'h8000_0000, 8'h07, 33'h0, 32'h0100_0000, 1'b1},
		'{3'h1, 1'b0, 32'h8000_0000, 8'h41, 33'h0, 32'h4000_0000, 1'b1},
		'{3'h3, 1'b0, 32'h7000_000F, 8'h04, 33'h0, 32'h0700_0000, 1'b0},
		'{3'h4, 1'b1, 32'h0, 8'h00, 33'h1_0000_0005, 32'h0000_0005, 1'b0},
		'{3'h5, 1'b0, 32'h0, 8'h00, 33'h0_8000_0000, 32'h7FFF_FFFF, 1'b0},
		'{3'h5, 1'b1, 32'h0, 8'h00, 33'h1_7FFF_FFFF, 32'h8000_0000, 1'b0},
		'{3'h5, 1'b0, 32'h0, 8'h00, 33'h1_FFFF_FFFE, 32'hFFFF_FFFE, 1'b0},
		'{3'h6, 1'b1, 32'h0, 8'h00, 33'h1_0000_0003, 32'hFFFF_FFFF, 1'b0},
		'{3'h6, 1'b0, 32'h0, 8'h00, 33'h0_1234_5678, 32'h1234_5678, 1'b0},
		'{3'h7, 1'b1, 32'h0, 8'h00, 33'h0, 32'h1234_5678, 1'b0}};

	shift_mac_unit DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dest_reg(dest), .cond_field_zero(cond), .fixed_point_exception_register(fpx));

	always #2 mclk = ~mclk;

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge mclk);
		while (ack !== 1'b1) @(posedge mclk);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic end_sim;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (2) @(posedge mclk);
		check("reset dest", 32'h0, dest);
		check("reset flags", 32'h0, 32'({cond, fpx}));
		rst_n <= 1'b1;
		ec = 4'h0;
		foreach (rows[i]) begin
			r = rows[i];
			// The immediate form gets a different amount register value, so a wrong count source shows.
			wb(1'b1, SRC_OFS, r.a);
			wb(1'b1, AMOUNT_OFS, {24'h00_0000, r.b + 8'(r.op == OP_SHR_ALG_IMM)});
			wb(1'b1, ACC_LO_OFS, r.acc[31:0]);
			wb(1'b1, ACC_HI_OFS, 32'(r.acc[32]));
			wb(1'b1, CTRL_OFS, {23'h00_0000, r.b[4:0], r.rec, r.op});
			if (r.rec && r.op != OP_NONE) ec = {r.res[31], !r.res[31] && r.res != 0, r.res == 0, 1'b0};
			check("dest", r.res, dest);
			check("carry", 32'(r.ca), 32'(fpx));
			check("cond", 32'(ec), 32'(cond));
		end
		wb(1'b1, FPX_OFS, 32'h0000_0006);
		wb(1'b1, SRC_OFS, 32'h8000_0000);
		wb(1'b1, CTRL_OFS, 32'h0000_000A);
		check("cond so", 32'h0000_0009, 32'(cond));
		wb(1'b0, FPX_OFS, 32'h0);
		check("flags read", 32'h0000_0006, rd);
		wb(1'b0, COND_OFS, 32'h0);
		check("cond read", 32'h0000_0009, rd);
		wb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl read", 32'h0000_000A, rd);
		wb(1'b0, SRC_OFS, 32'h0);
		check("src read", 32'h8000_0000, rd);
		wb(1'b1, ACC_HI_OFS, 32'h0000_0001);
		wb(1'b0, ACC_HI_OFS, 32'h0);
		check("acc hi read", 32'h0000_0001, rd);
		wb(1'b0, DEST_OFS, 32'h0);
		check("dest read", 32'h8000_0000, rd);
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped", 32'h0, rd);
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		check("mid reset dest", 32'h0, dest);
		check("mid reset flags", 32'h0, 32'({cond, fpx}));
		rst_n <= 1'b1;
		// The first request follows release at once, as the bus allows.
		wb(1'b0, FPX_OFS, 32'h0);
		check("flags after reset", 32'h0, rd);
		wb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl after reset", 32'h0, rd);
		end_sim();
	end
endmodule // test_shift_mac_unit
`default_nettype wire
